// File: src/alarm_consts.svh
// Offsets, field positions, reset values and timing of the thermal alarm block
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH
`define ADDR_TEMP 8'h00
`define ADDR_CFG 8'h01
`define ADDR_TLOW 8'h02
`define ADDR_THIGH 8'h03
`define ADDR_NV_CFG 8'h11
`define ADDR_NV_TLOW 8'h12
`define ADDR_NV_THIGH 8'h13
`define ADDR_STATUS 8'h20
`define BIT_SD 0
`define BIT_STYLE 1
`define BIT_POL 2
`define BIT_FQ_LO 3
`define BIT_FQ_HI 4
`define BIT_OS 7
`define CFG_MASK 16'h001f
`define NV_CFG_RESET 16'h0000
`define NV_TLOW_RESET 16'h4b00
`define NV_THIGH_RESET 16'h5000
`define DEPTH_SEL0 3'h1
`define DEPTH_SEL1 3'h2
`define DEPTH_SEL2 3'h4
`define DEPTH_SEL3 3'h6
`define CNT_MAX 3'h7
`define CLK_PERIOD_NS 100
`define PULSE_NS 1000
`endif

// File: src/alarm_pkg.sv
// Types shared by the thermal alarm block and its bench
package alarm_pkg;
  typedef logic [15:0] word_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    word_t wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic signed [15:0] value;
  } sample_t;
  typedef enum logic [0:0] {
    WAIT_HIGH = 1'b0,
    WAIT_LOW = 1'b1
  } expect_t;
endpackage

// File: src/temp_alarm.sv
// Thermal alarm: limit compare, fault queue, alert style and shutdown control
`timescale 1ns/1ps
`include "alarm_consts.svh"

module temp_alarm #(
  parameter logic [15:0] NV_CFG_INIT = `NV_CFG_RESET,
  parameter logic [15:0] NV_TLOW_INIT = `NV_TLOW_RESET,
  parameter logic [15:0] NV_THIGH_INIT = `NV_THIGH_RESET,
  parameter int PULSE_NS = `PULSE_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire alarm_pkg::reg_req_t req,
  output alarm_pkg::word_t rdata,
  // Serial side events
  input wire logic ara_ack,
  input wire logic gcall_reset,
  // Converter
  output logic sensor_run,
  input wire alarm_pkg::sample_t sample,
  // Alert pin, open drain
  output logic alert_out,
  output logic alert_oe
);
  import alarm_pkg::*;

  localparam int PULSE_CYC_RAW = (PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam logic [7:0] PULSE_LOAD = PULSE_CYC[7:0];

  if (PULSE_CYC > 255) begin : g_chk_pulse
    $error("alert pulse too long for its counter");
  end

  // Stored and working configuration
  word_t nv_cfg;
  word_t nv_tlow;
  word_t nv_thigh;
  word_t cfg;
  word_t tlow;
  word_t thigh;
  word_t temp;

  // Alarm state
  logic [2:0] count;
  logic last_hi;
  logic alert_latch;
  logic [7:0] pulse_cnt;
  logic valid_hi;
  logic valid_lo;
  logic oneshot_pend;
  logic boot_pend;
  expect_t expect_ev;

  // Register decode
  wire wr_cfg = req.wr && (req.addr == `ADDR_CFG);
  wire wr_tlow = req.wr && (req.addr == `ADDR_TLOW);
  wire wr_thigh = req.wr && (req.addr == `ADDR_THIGH);
  wire wr_nv_cfg = req.wr && (req.addr == `ADDR_NV_CFG);
  wire wr_nv_tlow = req.wr && (req.addr == `ADDR_NV_TLOW);
  wire wr_nv_thigh = req.wr && (req.addr == `ADDR_NV_THIGH);

  // Configuration fields
  wire sd = cfg[`BIT_SD];
  wire style_int = cfg[`BIT_STYLE];
  wire pol_high = cfg[`BIT_POL];
  wire [1:0] fq_sel = {cfg[`BIT_FQ_HI], cfg[`BIT_FQ_LO]};
  wire new_sd = req.wdata[`BIT_SD];
  wire sd_rise = wr_cfg && new_sd && !sd;
  wire sd_fall = wr_cfg && !new_sd && sd;
  wire os_req = wr_cfg && req.wdata[`BIT_OS] && new_sd;

  // Conversion control
  wire converting = !sd || oneshot_pend || boot_pend;
  wire take = sample.valid && converting;
  wire single = take && sd;

  // Limit compare
  wire signed [15:0] thigh_s = thigh;
  wire signed [15:0] tlow_s = tlow;
  wire hi_hit = take && (sample.value >= thigh_s);
  wire lo_hit = take && !hi_hit && (sample.value < tlow_s);
  wire fault = hi_hit || lo_hit;

  // Fault queue
  wire [2:0] depth = (fq_sel == 2'h0) ? `DEPTH_SEL0 :
                     (fq_sel == 2'h1) ? `DEPTH_SEL1 :
                     (fq_sel == 2'h2) ? `DEPTH_SEL2 : `DEPTH_SEL3;
  // A fault of the other kind starts a fresh run of consecutive faults
  wire kind_flip = fault && (count != 3'h0) && (hi_hit != last_hi);
  wire [2:0] cnt_base = kind_flip ? 3'h0 : count;
  wire [2:0] cnt_inc = (cnt_base == `CNT_MAX) ? cnt_base : cnt_base + 3'h1;
  wire [2:0] next_count = !take ? count :
                          fault ? cnt_inc : 3'h0;
  wire valid_now = fault && (cnt_inc >= depth);
  wire hi_valid = valid_now && hi_hit;
  wire lo_valid = valid_now && lo_hit;

  // Event sequencing
  wire want_hi = (expect_ev == WAIT_HIGH);
  wire match_ev = (want_hi && hi_valid) || (!want_hi && lo_valid);
  wire int_event = style_int && match_ev;
  wire exit_event = style_int && sd_fall &&
                    ((want_hi && valid_hi) || (!want_hi && valid_lo));
  wire int_pulse = int_event && single;
  wire int_latch = (int_event && !single) || exit_event;
  wire int_clear = style_int && (req.rd || ara_ack || sd_rise);
  wire cmp_set = !style_int && hi_valid;
  wire cmp_clr = !style_int && lo_valid;

  // Set wins over clear
  wire next_latch = (int_latch || cmp_set) ? 1'b1 :
                    (int_clear || cmp_clr) ? 1'b0 : alert_latch;
  wire [7:0] next_pulse = int_pulse ? PULSE_LOAD :
                          (pulse_cnt != 8'h0) ? pulse_cnt - 8'h1 : 8'h0;
  wire asserted = alert_latch || (pulse_cnt != 8'h0);
  wire pin_level = pol_high ? asserted : !asserted;

  expect_t next_expect;
  assign next_expect = (match_ev || exit_event) ?
                       (want_hi ? WAIT_LOW : WAIT_HIGH) : expect_ev;

  // Read mux
  word_t status;
  assign status = {8'h0, count, expect_ev, valid_hi, valid_lo,
                   converting, asserted};
  word_t rd_mux;
  assign rd_mux = (req.addr == `ADDR_TEMP) ? temp :
                  (req.addr == `ADDR_CFG) ? cfg :
                  (req.addr == `ADDR_TLOW) ? tlow :
                  (req.addr == `ADDR_THIGH) ? thigh :
                  (req.addr == `ADDR_NV_CFG) ? nv_cfg :
                  (req.addr == `ADDR_NV_TLOW) ? nv_tlow :
                  (req.addr == `ADDR_NV_THIGH) ? nv_thigh :
                  (req.addr == `ADDR_STATUS) ? status : 16'h0000;

  // Stored registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      nv_cfg <= NV_CFG_INIT & `CFG_MASK;
      nv_tlow <= NV_TLOW_INIT;
      nv_thigh <= NV_THIGH_INIT;
    end else begin
      if (wr_nv_cfg) begin
        nv_cfg <= req.wdata & `CFG_MASK;
      end
      if (wr_nv_tlow) begin
        nv_tlow <= req.wdata;
      end
      if (wr_nv_thigh) begin
        nv_thigh <= req.wdata;
      end
    end
  end

  // Working registers, loaded from the init values on reset and reloaded from storage on a general call reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg <= NV_CFG_INIT & `CFG_MASK;
      tlow <= NV_TLOW_INIT;
      thigh <= NV_THIGH_INIT;
    end else if (gcall_reset) begin
      cfg <= nv_cfg;
      tlow <= nv_tlow;
      thigh <= nv_thigh;
    end else begin
      if (wr_cfg) begin
        cfg <= req.wdata & `CFG_MASK;
      end
      if (wr_tlow) begin
        tlow <= req.wdata;
      end
      if (wr_thigh) begin
        thigh <= req.wdata;
      end
    end
  end

  // Conversion requests
  always_ff @(posedge mclk) begin
    if (reset) begin
      boot_pend <= NV_CFG_INIT[`BIT_SD];
      oneshot_pend <= 1'b0;
    end else if (gcall_reset) begin
      boot_pend <= nv_cfg[`BIT_SD];
      oneshot_pend <= 1'b0;
    end else begin
      if (take) begin
        boot_pend <= 1'b0;
      end
      if (os_req) begin
        oneshot_pend <= 1'b1;
      end else if (take || !sd) begin
        oneshot_pend <= 1'b0;
      end
    end
  end

  // Result register
  always_ff @(posedge mclk) begin
    if (reset) begin
      temp <= 16'h0000;
    end else if (take) begin
      temp <= sample.value;
    end
  end

  // Fault counter and last fault kind
  always_ff @(posedge mclk) begin
    if (reset || gcall_reset) begin
      count <= 3'h0;
      last_hi <= 1'b0;
      valid_hi <= 1'b0;
      valid_lo <= 1'b0;
      expect_ev <= WAIT_HIGH;
    end else begin
      count <= next_count;
      expect_ev <= next_expect;
      if (take && fault) begin
        last_hi <= hi_hit;
      end
      if (take) begin
        valid_hi <= hi_valid;
        valid_lo <= lo_valid;
      end
    end
  end

  // Alert state and pin
  always_ff @(posedge mclk) begin
    if (reset || gcall_reset) begin
      alert_latch <= 1'b0;
      pulse_cnt <= 8'h0;
    end else begin
      alert_latch <= next_latch;
      pulse_cnt <= next_pulse;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= !pin_level;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign alert_out = 1'b0;
  assign sensor_run = converting;

endmodule

// File: sim/temp_alarm_chk.sv
// Port checker for the thermal alarm block
`timescale 1ns/1ps
`include "alarm_consts.svh"
module temp_alarm_chk #(
  parameter logic [15:0] NV_CFG_INIT = `NV_CFG_RESET
) (
  input wire logic mclk,
  input wire logic reset,
  input wire alarm_pkg::reg_req_t req,
  input wire alarm_pkg::word_t rdata,
  input wire logic ara_ack,
  input wire logic gcall_reset,
  input wire logic sensor_run,
  input wire alarm_pkg::sample_t sample,
  input wire logic alert_out,
  input wire logic alert_oe
);
  import alarm_pkg::*;
  logic [2:0] cfg;
  logic [2:0] nv;
  wire cfg_wr = req.wr && req.addr == `ADDR_CFG;
  wire act = alert_oe ^ cfg[2];
  wire quiet = !req.rd && !ara_ack && !gcall_reset && !cfg_wr;
  // Shadow of the working shutdown, style and level bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      nv <= NV_CFG_INIT[2:0];
      cfg <= NV_CFG_INIT[2:0];
    end else begin
      if (req.wr && req.addr == `ADDR_NV_CFG) nv <= req.wdata[2:0];
      if (gcall_reset) cfg <= nv;
      else if (cfg_wr) cfg <= req.wdata[2:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RD_IDLE: assert property (!$past(req.rd) |-> rdata == 16'h0)
    else $error("read data not zero");
  AST_OD_LOW: assert property (alert_out == 1'b0)
    else $error("alert data not low");
  AST_CMP_HOLD: assert property (
    !cfg[1] && !sample.valid && !gcall_reset && !cfg_wr |=> ##1 $stable(alert_oe))
    else $error("comparator alert moved without a sample");
  AST_INT_HOLD: assert property (
    cfg[1:0] == 2'h2 && act && quiet && $past(quiet) |=> act)
    else $error("latched alert dropped");
  AST_INT_CLR: assert property (
    cfg[1:0] == 2'h2 && (req.rd || ara_ack) && !sample.valid && !cfg_wr |=> ##1 !act)
    else $error("latched alert not cleared");
  AST_GCALL: assert property (
    gcall_reset && !sample.valid |=> ##1 !act)
    else $error("alert kept over general call");
  AST_SD_INT: assert property (
    cfg_wr && req.wdata[1:0] == 2'h3 && !sample.valid |=> ##1 !act)
    else $error("alert kept on shutdown");
  AST_SD_CMP: assert property (
    cfg_wr && req.wdata[1:0] == 2'h1 && !cfg[1] && req.wdata[2] == cfg[2]
    && !sample.valid |=> ##1 $stable(alert_oe))
    else $error("comparator alert moved on shutdown");
endmodule

// File: sim/alert_host.sv
// Host model that answers an active alert line with an ARA cycle
`timescale 1ns/1ps
module alert_host #(
  parameter int DELAY = 3
) (
  input wire logic mclk,
  input wire logic alert_pin,
  input wire logic active_lvl,
  input wire logic enable,
  output logic ara_ack
);
  int cnt = 0;
  initial ara_ack = 1'b0;
  always @(posedge mclk) begin
    ara_ack <= 1'b0;
    if (!enable || alert_pin != active_lvl) begin
      cnt <= 0;
    end else if (cnt == DELAY) begin
      ara_ack <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: sim/temp_alarm_test.sv
// Self-checking bench for the thermal alarm block
`timescale 1ns/1ps
`include "alarm_consts.svh"
module temp_alarm_test;
  import alarm_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic gcall_reset = 1'b0;
  logic host_en = 1'b0;
  reg_req_t req = '0;
  sample_t sample = '0;
  word_t rdata;
  logic ara_ack, sensor_run, alert_out, alert_oe;
  int miscompares = 0;
  int n_checks = 0;
  // Pull-up on the open-drain line
  wire pin = alert_oe ? alert_out : 1'b1;
  always #50 mclk = ~mclk;
  temp_alarm u_temp_alarm (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
    .ara_ack(ara_ack), .gcall_reset(gcall_reset), .sensor_run(sensor_run),
    .sample(sample), .alert_out(alert_out), .alert_oe(alert_oe));
  alert_host u_alert_host (.mclk(mclk), .alert_pin(pin), .active_lvl(1'b0),
    .enable(host_en), .ara_ack(ara_ack));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t level %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input word_t exp);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge mclk) req <= '0;
    #1;
    n_checks++;
    if (rdata !== exp) begin
      miscompares++;
      $display("[ERR] %0t read %h gave %h, expected %h", $time, a, rdata, exp);
    end
  endtask
  task automatic feed(input word_t v, input logic exp);
    @(posedge mclk) sample <= '{1'b1, v};
    @(posedge mclk) sample <= '0;
    cyc(2);
    chk(pin, exp);
  endtask
  task automatic gc;
    @(posedge mclk) gcall_reset <= 1'b1;
    @(posedge mclk) gcall_reset <= 1'b0;
    cyc(2);
    chk(pin, 1'b1);
  endtask
  task automatic t_comparator;
    wr(`ADDR_CFG, 16'h0008);
    feed(16'h5000, 1'b1);
    feed(16'h4c00, 1'b1);
    feed(16'h5000, 1'b1);
    feed(16'h5000, 1'b0);
    rd(`ADDR_CFG, 16'h0008);
    wr(`ADDR_TLOW, 16'h4b00);
    cyc(2);
    chk(pin, 1'b0);
    feed(16'h4a00, 1'b0);
    feed(16'h4a00, 1'b1);
  endtask
  task automatic t_interrupt;
    gc();
    wr(`ADDR_CFG, 16'h0002);
    feed(16'h4a00, 1'b1);
    feed(16'h5000, 1'b0);
    cyc(5);
    chk(pin, 1'b0);
    rd(`ADDR_TLOW, 16'h4b00);
    cyc(2);
    chk(pin, 1'b1);
    feed(16'h5000, 1'b1);
    @(posedge mclk) host_en <= 1'b1;
    feed(16'h4a00, 1'b0);
    cyc(8);
    chk(pin, 1'b1);
    @(posedge mclk) host_en <= 1'b0;
  endtask
  task automatic t_boot;
    wr(`ADDR_NV_CFG, 16'h0001);
    gc();
    rd(`ADDR_CFG, 16'h0001);
    chk(sensor_run, 1'b1);
    feed(16'h4c00, 1'b1);
    chk(sensor_run, 1'b0);
    rd(`ADDR_TEMP, 16'h4c00);
    wr(`ADDR_NV_CFG, 16'h0000);
  endtask
  task automatic t_shutdown;
    feed(16'h5000, 1'b0);
    wr(`ADDR_CFG, 16'h0003);
    cyc(2);
    chk(pin, 1'b1);
    chk(sensor_run, 1'b0);
    rd(`ADDR_CFG, 16'h0003);
    wr(`ADDR_CFG, 16'h0083);
    for (int i = 0; i < 20 && sensor_run !== 1'b1; i++) cyc(1);
    feed(16'h4a00, 1'b0);
    cyc(12);
    chk(pin, 1'b1);
    chk(sensor_run, 1'b0);
  endtask
  task automatic t_switch;
    gc();
    wr(`ADDR_CFG, 16'h0000);
    feed(16'h5000, 1'b0);
    wr(`ADDR_CFG, 16'h0002);
    cyc(3);
    chk(pin, 1'b0);
    rd(`ADDR_TEMP, 16'h5000);
    cyc(2);
    chk(pin, 1'b1);
  endtask
  task automatic t_level;
    gc();
    wr(`ADDR_CFG, 16'h0004);
    cyc(2);
    chk(pin, 1'b0);
    feed(16'h5000, 1'b1);
    wr(`ADDR_CFG, 16'h0005);
    cyc(3);
    chk(pin, 1'b1);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_comparator();
    t_interrupt();
    t_shutdown();
    t_switch();
    t_level();
    t_boot();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule
bind temp_alarm temp_alarm_chk #(.NV_CFG_INIT(NV_CFG_INIT)) u_temp_alarm_chk (
  .mclk(mclk), .reset(reset), .req(req), .rdata(rdata), .ara_ack(ara_ack),
  .gcall_reset(gcall_reset), .sensor_run(sensor_run), .sample(sample),
  .alert_out(alert_out), .alert_oe(alert_oe));
